// >>> design/pwm_pkg.sv
// package: register map, field layout, modes and reset values of the pwm engine
package pwm_pkg;
  localparam logic [7:0]  ADDR_MODE     = 8'h00;
  localparam logic [7:0]  ADDR_POL      = 8'h04;
  localparam logic [7:0]  ADDR_LIMIT    = 8'h08;
  localparam logic [7:0]  ADDR_DUTY_UV  = 8'h0C;
  localparam logic [7:0]  ADDR_DUTY_WY  = 8'h10;
  localparam logic [7:0]  ADDR_STATUS   = 8'h14;

  localparam int          MODE_LSB      = 0;
  localparam int          MOTOR_LSB     = 4;
  localparam int          SPACE_VECTOR_ENABLE_BIT     = 8;
  localparam int          POL_LOW_BIT   = 0;
  localparam int          POL_HIGH_BIT  = 1;
  localparam int          DIR_BIT       = 16;

  localparam logic [2:0]  MODE_OFF        = 3'h0;
  localparam logic [2:0]  MODE_FREEWHEEL  = 3'h1;
  localparam logic [2:0]  MODE_BRAKE_LOW  = 3'h2;
  localparam logic [2:0]  MODE_BRAKE_HIGH = 3'h3;
  localparam logic [2:0]  MODE_CENTERED   = 3'h7;

  localparam logic [1:0]  CFG_THREE     = 2'h0;
  localparam logic [1:0]  CFG_STEPPER   = 2'h1;
  localparam logic [1:0]  CFG_DC        = 2'h2;
  localparam logic [3:0]  EN_THREE      = 4'h7;
  localparam logic [3:0]  EN_STEPPER    = 4'hF;
  localparam logic [3:0]  EN_DC         = 4'h3;

  localparam logic [15:0] LIMIT_RESET   = 16'h0F9F;
  localparam logic [15:0] CNT_STEP      = 16'h0002;
  localparam logic [15:0] DUTY_OFFSET   = 16'h8000;
  localparam logic [15:0] S16_MAX       = 16'h7FFF;
  localparam logic [15:0] S16_MIN       = 16'h8000;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// >>> design/centered_gate_pwm_engine.sv
// centre-aligned gate pwm engine for four half bridges with an axi4-lite register slave
`timescale 1ns/100ps
module centered_gate_pwm_engine
  import pwm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             bridge1_high_gate,
  output logic             bridge1_low_gate,
  output logic             bridge2_high_gate,
  output logic             bridge2_low_gate,
  output logic             bridge3_high_gate,
  output logic             bridge3_low_gate,
  output logic             bridge4_high_gate,
  output logic             bridge4_low_gate
);
  typedef struct packed {
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       aw_addr;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic [2:0]       mode;
    logic [1:0]       motor;
    logic             sv_en;
    logic [1:0]       pol;
    logic [15:0]      limit;
    logic [15:0]      limit_act;
    logic [15:0]      cnt;
    logic             down;
    logic [3:0][15:0] duty;
    logic [3:0]       gate_h;
    logic [3:0]       gate_l;
  } state_t;
  state_t           s_q;
  state_t           s_d;
  logic [3:0]       pulse;
  logic [3:0]       en_mask;
  logic [16:0]      sv_off;
  logic [3:0][16:0] adj;
  logic [3:0][15:0] sat;
  logic [16:0]      ext_max;
  logic [16:0]      ext_min;
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] data, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction
  function automatic logic [16:0] sx(logic [15:0] v);
    return {v[15], v};
  endfunction
  // common-mode offset of the three phases: (max + min) / 2
  always_comb begin
    ext_max = sx(s_q.duty[0]);
    ext_min = sx(s_q.duty[0]);
    for (int i = 1; i < 3; i++) begin
      if ($signed(sx(s_q.duty[i])) > $signed(ext_max)) begin
        ext_max = sx(s_q.duty[i]);
      end
      if ($signed(sx(s_q.duty[i])) < $signed(ext_min)) begin
        ext_min = sx(s_q.duty[i]);
      end
    end
    sv_off = 17'($signed(17'(ext_max + ext_min)) >>> 1);
  end
  always_comb begin
    unique case (s_q.motor)
      CFG_STEPPER: en_mask = EN_STEPPER;
      CFG_DC:      en_mask = EN_DC;
      default:     en_mask = EN_THREE;
    endcase
  end
  // per bridge: optional space vector shift, saturate, offset to unsigned, scale to limit
  for (genvar i = 0; i < 4; i++) begin : g_bridge
    logic [15:0] u;
    logic [32:0] prod;
    logic [16:0] thr;
    always_comb begin
      adj[i] = (s_q.sv_en && s_q.motor == CFG_THREE && i < 3)
               ? 17'(sx(s_q.duty[i]) - sv_off) : sx(s_q.duty[i]);
      sat[i] = (adj[i][16] == adj[i][15]) ? adj[i][15:0]
               : (adj[i][16] ? S16_MIN : S16_MAX);
    end
    assign u        = sat[i] + DUTY_OFFSET;
    // threshold scales with limit, so resolution tracks the period length
    assign prod     = u * ({1'b0, s_q.limit_act} + 17'h00001);
    assign thr      = prod[32:16];
    assign pulse[i] = ({1'b0, s_q.cnt} < thr);
  end
  always_comb begin
    logic [31:0] wd;
    logic [3:0]  ih;
    logic [3:0]  il;
    wd = 32'h0000_0000;
    ih = 4'h0;
    il = 4'h0;
    s_d = s_q;
    // write channel: address and data taken in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OKAY;
      unique case (s_q.aw_addr)
        ADDR_MODE: begin
          wd = merge({23'h0, s_q.sv_en, 2'h0, s_q.motor, 1'b0, s_q.mode},
                     s_q.w_data, s_q.w_strb);
          s_d.mode  = wd[MODE_LSB +: 3];
          s_d.motor = wd[MOTOR_LSB +: 2];
          s_d.sv_en = wd[SPACE_VECTOR_ENABLE_BIT];
        end
        ADDR_POL: begin
          wd = merge({30'h0, s_q.pol}, s_q.w_data, s_q.w_strb);
          s_d.pol = wd[1:0];
        end
        ADDR_LIMIT: begin
          wd = merge({16'h0, s_q.limit}, s_q.w_data, s_q.w_strb);
          s_d.limit = wd[15:0];
        end
        ADDR_DUTY_UV: begin
          wd = merge({s_q.duty[1], s_q.duty[0]}, s_q.w_data, s_q.w_strb);
          s_d.duty[0] = wd[15:0];
          s_d.duty[1] = wd[31:16];
        end
        ADDR_DUTY_WY: begin
          wd = merge({s_q.duty[3], s_q.duty[2]}, s_q.w_data, s_q.w_strb);
          s_d.duty[2] = wd[15:0];
          s_d.duty[3] = wd[31:16];
        end
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_have;
    s_d.wready  = !s_d.w_have;
    // read channel: one read at a time, answer one cycle after the address
    if (s_q.rvalid && rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
    if (arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = RESP_OKAY;
      unique case (araddr)
        ADDR_MODE:    s_d.rdata = {23'h0, s_q.sv_en, 2'h0, s_q.motor, 1'b0, s_q.mode};
        ADDR_POL:     s_d.rdata = {30'h0, s_q.pol};
        ADDR_LIMIT:   s_d.rdata = {16'h0, s_q.limit};
        ADDR_DUTY_UV: s_d.rdata = {s_q.duty[1], s_q.duty[0]};
        ADDR_DUTY_WY: s_d.rdata = {s_q.duty[3], s_q.duty[2]};
        ADDR_STATUS:  s_d.rdata = {15'h0, s_q.down, s_q.cnt};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = RESP_SLVERR;
        end
      endcase
    end
    // triangle counter; a new limit is adopted only at the bottom to avoid runt pulses
    if (s_q.mode != MODE_CENTERED) begin
      s_d.cnt       = 16'h0000;
      s_d.down      = 1'b0;
      s_d.limit_act = s_q.limit;
    end else if (!s_q.down) begin
      if ({1'b0, s_q.cnt} + {1'b0, CNT_STEP} >= {1'b0, s_q.limit_act}) begin
        s_d.cnt  = s_q.limit_act;
        s_d.down = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + CNT_STEP;
      end
    end else if (s_q.cnt <= CNT_STEP) begin
      s_d.cnt       = 16'h0000;
      s_d.down      = 1'b0;
      s_d.limit_act = s_q.limit;
    end else begin
      s_d.cnt = s_q.cnt - CNT_STEP;
    end
    unique case (s_q.mode)
      MODE_CENTERED: begin
        ih = pulse & en_mask;
        il = ~pulse & en_mask;
      end
      MODE_BRAKE_LOW:  il = en_mask;
      MODE_BRAKE_HIGH: ih = en_mask;
      // freewheel and off leave both sides at their inactive level
      default:         ih = 4'h0;
    endcase
    s_d.gate_h = ih ^ {4{s_q.pol[POL_HIGH_BIT]}};
    s_d.gate_l = il ^ {4{s_q.pol[POL_LOW_BIT]}};
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q           <= '0;
      s_q.awready   <= 1'b1;
      s_q.wready    <= 1'b1;
      s_q.arready   <= 1'b1;
      s_q.mode      <= MODE_OFF;
      s_q.limit     <= LIMIT_RESET;
      s_q.limit_act <= LIMIT_RESET;
    end else begin
      s_q <= s_d;
    end
  end
  assign awready           = s_q.awready;
  assign wready            = s_q.wready;
  assign bvalid            = s_q.bvalid;
  assign bresp             = s_q.bresp;
  assign arready           = s_q.arready;
  assign rvalid            = s_q.rvalid;
  assign rresp             = s_q.rresp;
  assign rdata             = s_q.rdata;
  assign bridge1_high_gate = s_q.gate_h[0];
  assign bridge1_low_gate  = s_q.gate_l[0];
  assign bridge2_high_gate = s_q.gate_h[1];
  assign bridge2_low_gate  = s_q.gate_l[1];
  assign bridge3_high_gate = s_q.gate_h[2];
  assign bridge3_low_gate  = s_q.gate_l[2];
  assign bridge4_high_gate = s_q.gate_h[3];
  assign bridge4_low_gate  = s_q.gate_l[3];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_off_quiet;
    s_q.mode == MODE_OFF |=> s_q.gate_h == {4{$past(s_q.pol[POL_HIGH_BIT])}}
                            && s_q.gate_l == {4{$past(s_q.pol[POL_LOW_BIT])}};
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("gates switch in off mode");
  property p_reset_limit;
    $past(reset) |-> s_q.limit == LIMIT_RESET && s_q.mode == MODE_OFF;
  endproperty
  a_reset_limit: assert property (p_reset_limit) else $error("wrong reset value");
  property p_cnt_bound;
    s_q.cnt <= s_q.limit_act;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("counter above limit");
  property p_cnt_up;
    s_q.mode == MODE_CENTERED && $past(s_q.mode) == MODE_CENTERED && !s_q.down
      && {1'b0, s_q.cnt} + {1'b0, CNT_STEP} < {1'b0, s_q.limit_act}
      |=> s_q.cnt == 16'($past(s_q.cnt) + CNT_STEP) ##1 s_q.cnt != $past(s_q.cnt);
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("counter step wrong");
  property p_high_pol;
    s_q.mode == MODE_CENTERED && s_q.motor == CFG_THREE
      |=> s_q.gate_h[0] == ($past(pulse[0]) ^ $past(s_q.pol[POL_HIGH_BIT]));
  endproperty
  a_high_pol: assert property (p_high_pol) else $error("high side polarity wrong");
  property p_low_pol;
    s_q.mode == MODE_CENTERED && s_q.motor == CFG_THREE
      |=> s_q.gate_l[0] == (!$past(pulse[0]) ^ $past(s_q.pol[POL_LOW_BIT]));
  endproperty
  a_low_pol: assert property (p_low_pol) else $error("low side polarity wrong");
  property p_dc_unused;
    s_q.mode == MODE_CENTERED && s_q.motor == CFG_DC
      |=> s_q.gate_h[3:2] == {2{$past(s_q.pol[POL_HIGH_BIT])}};
  endproperty
  a_dc_unused: assert property (p_dc_unused) else $error("unused bridge switches");
  property p_limit_swap;
    s_q.limit_act != $past(s_q.limit_act) |-> s_q.cnt == 16'h0000;
  endproperty
  a_limit_swap: assert property (p_limit_swap) else $error("limit adopted mid period");
  // bridges 1 and 2 are in use for every motor type, so any braking run reaches this
  property p_brake_low;
    s_q.mode == MODE_BRAKE_LOW
      |=> s_q.gate_l[1:0] == ~{2{$past(s_q.pol[POL_LOW_BIT])}}
          && s_q.gate_h[1:0] == {2{$past(s_q.pol[POL_HIGH_BIT])}};
  endproperty
  a_brake_low: assert property (p_brake_low) else $error("braking low sides off");
  property p_sv_off;
    !s_q.sv_en |-> adj[0] == sx(s_q.duty[0]);
  endproperty
  a_sv_off: assert property (p_sv_off) else $error("offset applied with space_vector_enable off");
  property p_bvalid_hold;
    s_q.bvalid |=> s_q.bvalid || $past(bready);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
  c_centered: cover property (s_q.mode == MODE_CENTERED && s_q.down ##1 !s_q.down);
  c_sv_on:    cover property (s_q.sv_en && s_q.mode == MODE_CENTERED);
  c_limit:    cover property (s_q.limit_act != $past(s_q.limit_act));
endmodule

// >>> sim/gate_driver_model.sv
// gate driver model: counts high cycles and rising edges of each gate line
`timescale 1ns/100ps
module gate_driver_model (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [7:0] gate,
  output int              hi_cnt [8],
  output int              rise_cnt [8]
);
  logic [7:0] prev_q;
  // drivers only listen, so nothing is driven back onto the gate lines
  always_ff @(posedge clk) begin
    prev_q <= gate;
    for (int i = 0; i < 8; i++) begin
      if (clr) begin
        hi_cnt[i]   <= 0;
        rise_cnt[i] <= 0;
      end else begin
        // an unknown level counts heavily, so no range check can let it through
        hi_cnt[i]   <= hi_cnt[i] + ($isunknown(gate[i]) ? 4096 : int'(gate[i]));
        rise_cnt[i] <= rise_cnt[i] + int'(gate[i] & ~prev_q[i]);
      end
    end
  end
endmodule

// >>> sim/testbench.sv
// testbench: register access over axi4-lite and gate waveform checks
`timescale 1ns/100ps
module testbench;
  import pwm_pkg::*;
  logic        clk, reset, clr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  wire  [7:0]  gate;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          hi [8];
  int          rs [8];
  int          n_fail, checks_done, eh, el;

  centered_gate_pwm_engine uut (
    .clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .bridge1_high_gate(gate[0]), .bridge1_low_gate(gate[1]),
    .bridge2_high_gate(gate[2]), .bridge2_low_gate(gate[3]),
    .bridge3_high_gate(gate[4]), .bridge3_low_gate(gate[5]),
    .bridge4_high_gate(gate[6]), .bridge4_low_gate(gate[7])
  );
  gate_driver_model drv (.clk(clk), .clr(clr), .gate(gate), .hi_cnt(hi), .rise_cnt(rs));

  always #2 clk = ~clk;

  task automatic wrap_up;
    $display("checks_done %0d n_fail %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int up);
    checks_done++;
    if (got < lo || got > up) begin
      n_fail++;
      $display("CHECK FAILED t=%0t count %0d not in %0d..%0d", $time, got, lo, up);
    end
  endtask

  // bready and rready stay high, so every answer is taken at its first edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) begin
      n_fail++;
      wrap_up();
    end
    chk(32'(bresp), 32'(er));
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int k;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) begin
      n_fail++;
      wrap_up();
    end
    rd  = rdata;
    rsp = rresp;
  endtask

  // window of w cycles; a whole number of periods makes counts phase independent
  task automatic meas(input int w);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
  endtask

  initial begin
    clk = 0; reset = 1; clr = 0; awvalid = 0; wvalid = 0; arvalid = 0;
    bready = 1; rready = 1; awaddr = 0; araddr = 0; wdata = 0; wstrb = 4'hF;
    n_fail = 0; checks_done = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd_reg(ADDR_MODE);
    chk(rd, 32'h0);
    rd_reg(ADDR_POL);
    chk(rd, 32'h0);
    rd_reg(ADDR_LIMIT);
    chk(rd, 32'h00000F9F);
    meas(64);
    for (int i = 0; i < 8; i++) chk_rng(hi[i] + rs[i], 0, 0);
    rd_reg(8'h18);
    chk(rd, 32'h0);
    chk(32'(rsp), 32'(RESP_SLVERR));
    wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
    wr(ADDR_LIMIT, 32'h0000000F, RESP_OKAY);
    wr(ADDR_MODE, 32'h00000017, RESP_OKAY);
    meas(32);
    meas(64);
    for (int b = 0; b < 4; b++) begin
      chk_rng(rs[2*b], 4, 4);
      chk_rng(hi[2*b], 28, 36);
      chk_rng(hi[2*b] + hi[2*b+1], 64, 64);
    end
    wr(ADDR_DUTY_UV, 32'h7FFF8000, RESP_OKAY);
    meas(64);
    chk_rng(hi[0] + rs[0], 0, 0);
    chk_rng(hi[2], 48, 64);
    // bridge1 internal high never on and internal low always on, so the high gate shows its polarity bit and the low gate its inverse
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_POL, 32'(p), RESP_OKAY);
      meas(64);
      chk_rng(hi[0], (p / 2) * 64, (p / 2) * 64);
      chk_rng(hi[1], (1 - p % 2) * 64, (1 - p % 2) * 64);
    end
    wr(ADDR_POL, 32'h0, RESP_OKAY);
    // pole pairs are kept by software outside this block, set to 1 for dc use
    wr(ADDR_MODE, 32'h00000027, RESP_OKAY);
    meas(64);
    for (int i = 4; i < 8; i++) chk_rng(hi[i] + rs[i], 0, 0);
    wr(ADDR_MODE, 32'h00000007, RESP_OKAY);
    meas(64);
    chk_rng(rs[4], 4, 4);
    chk_rng(hi[6] + hi[7], 0, 0);
    // no controller sits behind this period change, so no gains to retune
    wr(ADDR_LIMIT, 32'h0000001F, RESP_OKAY);
    meas(64);
    meas(128);
    chk_rng(rs[4], 4, 4);
    chk_rng(hi[4], 60, 68);
    wr(ADDR_LIMIT, 32'h000000FF, RESP_OKAY);
    wr(ADDR_DUTY_UV, 32'h00004000, RESP_OKAY);
    meas(512);
    meas(256);
    chk_rng(hi[2], 124, 132);
    wr(ADDR_MODE, 32'h00000107, RESP_OKAY);
    rd_reg(ADDR_MODE);
    chk(rd, 32'h00000107);
    meas(512);
    meas(256);
    chk_rng(hi[2], 92, 100);
    for (int m = 1; m < 5; m++) begin
      wr(ADDR_MODE, 32'(m % 4), RESP_OKAY);
      eh = (m == 3) ? 256 : 0;
      el = (m == 2) ? 256 : 0;
      meas(256);
      chk_rng(hi[0], eh, eh);
      chk_rng(hi[1], el, el);
      chk_rng(rs[0] + rs[1], 0, 0);
    end
    rd_reg(ADDR_STATUS);
    chk(rd, 32'h0);
    chk(32'(rsp), 32'(RESP_OKAY));
    wrap_up();
  end
endmodule
